// file: pkg/insn_exec_map.vh
`ifndef INSN_EXEC_MAP_VH
`define INSN_EXEC_MAP_VH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define IW_MSB 11
`define IW_ADDR_MSB 4
`define IW_DEST_BIT 5
`define IW_OPC_MSB 11
`define IW_OPC_LSB 6

// ----------------------------------------
// Opcode patterns, upper six bits; the sleep code is the whole 12-bit word
// ----------------------------------------
`define OPC_ROTATE_RIGHT 6'h0c
`define OPC_SUBTRACT 6'h02
`define CODE_SLEEP 12'h003

// ----------------------------------------
// Reset and load values, and bit positions
// ----------------------------------------
`define ZERO_BYTE 8'h00
`define WATCHDOG_LOAD 8'h00
`define NIBBLE_MSB 3
`define ROT_CARRY_BIT 0

`endif

// file: core/subtract_unit.v
`include "insn_exec_map.vh"

// Combinational file minus accumulator with borrow-style flags
module subtract_unit #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] file_in,
  input wire [WIDTH-1:0] acc_in,
  output wire [WIDTH-1:0] diff_out,
  output wire carry_out,
  output wire digit_carry_out,
  output wire zero_out
);

  wire [WIDTH:0] sum;
  wire [4:0] low_sum;

  // Two's complement: f + ~w + 1; carry set means no borrow
  assign sum = {1'b0, file_in} + {1'b0, ~acc_in} + {{WIDTH{1'b0}}, 1'b1};
  assign low_sum = {1'b0, file_in[`NIBBLE_MSB:0]}
                 + {1'b0, ~acc_in[`NIBBLE_MSB:0]} + 5'h01;
  assign diff_out = sum[WIDTH-1:0];
  assign carry_out = sum[WIDTH];
  assign digit_carry_out = low_sum[4];
  assign zero_out = (sum[WIDTH-1:0] == {WIDTH{1'b0}});

endmodule

// file: core/rotate_subtract_sleep_exec.v
// Summary of operation
// - Rotate and subtract take a file address 0..31 and a destination bit.
// - Rotate right decodes from 0011 00df ffff and may change only carry.
// - Rotate right shifts toward bit 0; old carry to bit 7, bit 0 to carry.
// - Rotate result goes to the accumulator for d=0, to the file for d=1.
// - Sleep decodes only from the exact code 0000 0000 0011, no operands.
// - Sleep sets expiry, clears sleep entered, leaves the wake flag alone.
// - Sleep loads the watchdog counter with 00h and clears its prescaler.
// - Sleep stops the oscillator and halts execution until a wake condition.
// - Subtract, 0000 10df ffff, gives file minus accumulator; sets C, DC, Z.
// - Subtract result goes to the accumulator for d=0, to the file for d=1.
// - After subtract carry is 1 for a zero or positive result, 0 on borrow.
`include "insn_exec_map.vh"

module rotate_subtract_sleep_exec #(
  parameter WIDTH = 8,
  parameter ADDR_W = 5
) (
  input wire mclk_in,
  input wire reset_n_in,
  input wire clk_en_in,
  input wire insn_valid_in,
  input wire [`IW_MSB:0] insn_word_in,
  input wire [WIDTH-1:0] file_data_in,
  input wire [WIDTH-1:0] acc_in,
  input wire carry_in,
  input wire wake_in,
  output reg [ADDR_W-1:0] file_addr_out,
  output reg [WIDTH-1:0] result_out,
  output reg acc_we_out,
  output reg file_we_out,
  output reg carry_we_out,
  output reg carry_out,
  output reg dc_z_we_out,
  output reg digit_carry_out,
  output reg zero_out,
  output reg status_we_out,
  output reg expiry_status_bit_out,
  output reg sleep_entered_bit_out,
  output reg watchdog_clear_out,
  output reg watchdog_counter_out,
  output reg osc_stop_out,
  output reg sleeping_out,
  output reg done_out
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // One-hot: two flops, one per state, tell run from sleep
  localparam ST_RUN = 2'b01;
  localparam ST_SLEEP = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  wire [5:0] opc;
  wire dest;
  wire [ADDR_W-1:0] faddr;
  wire is_rotate;
  wire is_sub;
  wire is_sleep;
  wire go;
  wire [WIDTH-1:0] rot_val;
  wire [WIDTH-1:0] diff;
  wire sub_c;
  wire sub_dc;
  wire sub_z;
  wire any_alu;
  wire [WIDTH-1:0] nxt_result;
  wire nxt_carry;
  wire stay_asleep;

  assign opc = insn_word_in[`IW_OPC_MSB:`IW_OPC_LSB];
  assign dest = insn_word_in[`IW_DEST_BIT];
  assign faddr = insn_word_in[`IW_ADDR_MSB:0];
  // Words that arrive while asleep are dropped, not held
  assign go = insn_valid_in & (state_ff == ST_RUN);
  assign is_rotate = go & (opc == `OPC_ROTATE_RIGHT);
  assign is_sub = go & (opc == `OPC_SUBTRACT);
  // Whole-word compare: other codes of the same group must not sleep
  assign is_sleep = go & (insn_word_in == `CODE_SLEEP);
  assign any_alu = is_rotate | is_sub;

  // ----------------------------------------
  // Rotate right through carry
  // ----------------------------------------
  // Each bit takes its upper neighbour; the top bit takes the old carry
  genvar bit_i;
  generate
    for (bit_i = 0; bit_i < WIDTH; bit_i = bit_i + 1) begin : g_rot
      if (bit_i == WIDTH - 1) begin : g_top
        assign rot_val[bit_i] = carry_in;
      end else begin : g_low
        assign rot_val[bit_i] = file_data_in[bit_i + 1];
      end
    end
  endgenerate

  // ----------------------------------------
  // Subtract and result select
  // ----------------------------------------
  // Both results are formed every cycle; the decode picks one
  subtract_unit #(
    .WIDTH(WIDTH)
  ) u_sub (
    .file_in(file_data_in),
    .acc_in(acc_in),
    .diff_out(diff),
    .carry_out(sub_c),
    .digit_carry_out(sub_dc),
    .zero_out(sub_z)
  );

  assign nxt_result = is_rotate ? rot_val : diff;
  assign nxt_carry = is_rotate ? file_data_in[`ROT_CARRY_BIT] : sub_c;

  // ----------------------------------------
  // Sleep state
  // ----------------------------------------
  always @* begin
    case (state_ff)
      ST_RUN: begin
        nxt_state = is_sleep ? ST_SLEEP : ST_RUN;
      end
      ST_SLEEP: begin
        nxt_state = wake_in ? ST_RUN : ST_SLEEP;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // Sleep state register
  // ----------------------------------------
  // Frozen with the clock enable, like every other register here
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ST_RUN;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  // One enabled cycle each; the core must act on them at once
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      file_addr_out <= {ADDR_W{1'b0}};
      acc_we_out <= 1'b0;
      file_we_out <= 1'b0;
      carry_we_out <= 1'b0;
      dc_z_we_out <= 1'b0;
      done_out <= 1'b0;
    end else if (clk_en_in) begin
      file_addr_out <= faddr;
      acc_we_out <= any_alu & ~dest;
      file_we_out <= any_alu & dest;
      // Rotate leaves DC and Z alone, so only carry is written
      carry_we_out <= any_alu;
      dc_z_we_out <= is_sub;
      done_out <= any_alu | is_sleep;
    end
  end

  // ----------------------------------------
  // Result and arithmetic flags
  // ----------------------------------------
  // Held between instructions so a late write-back still reads them
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_out <= `ZERO_BYTE;
      carry_out <= 1'b0;
      digit_carry_out <= 1'b0;
      zero_out <= 1'b0;
    end else if (clk_en_in) begin
      if (any_alu) begin
        result_out <= nxt_result;
        carry_out <= nxt_carry;
      end
      if (is_sub) begin
        digit_carry_out <= sub_dc;
        zero_out <= sub_z;
      end
    end
  end

  // ----------------------------------------
  // Sleep entry and watchdog
  // ----------------------------------------
  // Limitation: wake is only seen on a clock edge, so the core must keep
  // this block clocked while its main oscillator is stopped
  assign stay_asleep = (nxt_state == ST_SLEEP);

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_we_out <= 1'b0;
      expiry_status_bit_out <= 1'b0;
      sleep_entered_bit_out <= 1'b0;
      watchdog_clear_out <= 1'b0;
      watchdog_counter_out <= 1'b0;
      osc_stop_out <= 1'b0;
      sleeping_out <= 1'b0;
    end else if (clk_en_in) begin
      // Wake flag has no port here, so sleep cannot disturb it
      status_we_out <= is_sleep;
      watchdog_clear_out <= is_sleep;
      // Counter load pulse: the core loads 00h on this strobe
      watchdog_counter_out <= is_sleep;
      if (is_sleep) begin
        expiry_status_bit_out <= 1'b1;
        sleep_entered_bit_out <= 1'b0;
      end
      osc_stop_out <= stay_asleep;
      sleeping_out <= stay_asleep;
    end
  end

endmodule

// file: tb/rss_chk.sv
module rss_chk (
  input wire mclk_in,
  input wire reset_n_in,
  input wire clk_en_in,
  input wire insn_valid_in,
  input wire carry_in,
  input wire wake_in,
  input wire [11:0] insn_word_in,
  input wire [7:0] file_data_in,
  input wire [7:0] acc_in,
  input wire [7:0] result_out,
  input wire carry_out,
  input wire zero_out,
  input wire dc_z_we_out,
  input wire acc_we_out,
  input wire file_we_out,
  input wire done_out,
  input wire expiry_status_bit_out,
  input wire sleep_entered_bit_out,
  input wire sleeping_out,
  input wire watchdog_clear_out,
  input wire watchdog_counter_out,
  input wire osc_stop_out
);
  // ----------------------------------------
  // Decode seen at the ports
  // ----------------------------------------
  wire go = clk_en_in && insn_valid_in && !sleeping_out;
  wire rot = go && insn_word_in[11:6] == 6'h0c;
  wire sub = go && insn_word_in[11:6] == 6'h02;
  wire slp = go && insn_word_in == 12'h003;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  property p_rr;
    rot |=> result_out == {$past(carry_in), $past(file_data_in[7:1])};
  endproperty
  a_rr: assert property (p_rr) else $error("rotate value");
  property p_rc; rot |=> carry_out == $past(file_data_in[0]); endproperty
  a_rc: assert property (p_rc) else $error("rotate carry");
  property p_rd;
    rot |=> file_we_out == $past(insn_word_in[5]) && acc_we_out != file_we_out;
  endproperty
  a_rd: assert property (p_rd) else $error("rotate dest");
  property p_sd;
    sub |=> result_out == $past(file_data_in) - $past(acc_in);
  endproperty
  a_sd: assert property (p_sd) else $error("subtract value");
  property p_sc;
    sub |=> carry_out == ($past(file_data_in) >= $past(acc_in));
  endproperty
  a_sc: assert property (p_sc) else $error("subtract carry");
  property p_sz;
    sub |=> zero_out == ($past(file_data_in) == $past(acc_in));
  endproperty
  a_sz: assert property (p_sz) else $error("subtract zero");
  property p_ro; rot |=> !dc_z_we_out; endproperty
  a_ro: assert property (p_ro) else $error("rotate flags");
  property p_sl;
    slp |=> expiry_status_bit_out && !sleep_entered_bit_out && osc_stop_out
      && watchdog_clear_out && watchdog_counter_out;
  endproperty
  a_sl: assert property (p_sl) else $error("sleep entry");
  property p_hz; sleeping_out && !wake_in |=> sleeping_out && !done_out;
  endproperty
  a_hz: assert property (p_hz) else $error("sleep halt");
  property p_nm; go && !(rot || sub || slp) |=> !done_out; endproperty
  a_nm: assert property (p_nm) else $error("foreign word");
  property p_dn; rot || sub || slp |=> done_out; endproperty
  a_dn: assert property (p_dn) else $error("one cycle");
endmodule

bind rotate_subtract_sleep_exec rss_chk rss_chk_i (.*);

// file: tb/rotate_subtract_sleep_exec_tb.sv
module rotate_subtract_sleep_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, reset_n_in = 0, clk_en_in = 1, insn_valid_in = 0;
  logic carry_in = 0, wake_in = 0;
  logic [11:0] insn_word_in = 12'h000;
  logic [7:0] file_data_in = 8'h00, acc_in = 8'h00;
  wire [4:0] file_addr_out;
  wire [7:0] result_out;
  wire acc_we_out, file_we_out, carry_we_out, carry_out, dc_z_we_out;
  wire digit_carry_out, zero_out, status_we_out, expiry_status_bit_out;
  wire sleep_entered_bit_out, watchdog_clear_out, watchdog_counter_out;
  wire osc_stop_out, sleeping_out, done_out;
  int err_total = 0, comparisons = 0, cycles = 0;
  rotate_subtract_sleep_exec rotate_subtract_sleep_exec_i (.*);
  always #25 mclk_in = ~mclk_in;
  // Whole run is well under 100 cycles
  always @(posedge mclk_in) if (++cycles == 2000) begin
    err_total++;
    stop_test();
  end
  task stop_test();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task run(input logic [11:0] w, input logic [7:0] f, a, input logic c);
    @(posedge mclk_in);
    #1 {insn_valid_in, insn_word_in, file_data_in, acc_in, carry_in} =
      {1'b1, w, f, a, c};
    @(posedge mclk_in);
    #1 insn_valid_in = 0;
    $display("test %h end", w);
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    #1 reset_n_in = 1;
    run(12'h325, 8'h01, 8'h00, 1);
    chk(result_out, 8'h80);
    chk({file_we_out, acc_we_out, carry_out, done_out}, 8'h0b);
    chk(file_addr_out, 8'h05);
    run(12'h31f, 8'he6, 8'h00, 0);
    chk(result_out, 8'h73);
    chk({acc_we_out, file_we_out, file_addr_out}, 8'h5f);
    chk({carry_out, carry_we_out, dc_z_we_out}, 8'h02);
    run(12'h0a3, 8'h03, 8'h02, 0);
    chk(result_out, 8'h01);
    chk({file_we_out, carry_out, digit_carry_out, zero_out}, 8'h0e);
    run(12'h083, 8'h02, 8'h02, 0);
    chk(result_out, 8'h00);
    chk({acc_we_out, carry_out, digit_carry_out, zero_out}, 8'h0f);
    run(12'h083, 8'h01, 8'h02, 1);
    chk(result_out, 8'hff);
    chk({carry_out, digit_carry_out, zero_out, dc_z_we_out}, 8'h01);
    run(12'h0a3, 8'h10, 8'h01, 0);
    chk(result_out, 8'h0f);
    chk({carry_out, digit_carry_out, zero_out}, 8'h04);
    run(12'h013, 8'h01, 8'h00, 1);
    chk(done_out, 8'h00);
    run(12'h343, 8'h01, 8'h00, 1);
    chk(done_out, 8'h00);
    clk_en_in = 0;
    run(12'h003, 8'h00, 8'h00, 0);
    chk({done_out, sleeping_out}, 8'h00);
    clk_en_in = 1;
    run(12'h003, 8'h00, 8'h00, 0);
    chk({status_we_out, expiry_status_bit_out, sleep_entered_bit_out,
      watchdog_clear_out, watchdog_counter_out, osc_stop_out, sleeping_out,
      done_out}, 8'hdf);
    run(12'h325, 8'h01, 8'h00, 1);
    chk({done_out, status_we_out, watchdog_counter_out, sleeping_out},
      8'h01);
    wake_in = 1;
    @(posedge mclk_in);
    #1 wake_in = 0;
    chk({sleeping_out, osc_stop_out}, 8'h00);
    stop_test();
  end
endmodule
